// File: rtl/cts_defines.svh
// Register offsets, field positions, reset values and check vector locations.
`ifndef CTS_DEFINES_SVH
`define CTS_DEFINES_SVH
`define CTS_CTRL_OFF 12'h000
`define CTS_STATUS_OFF 12'h004
`define CTS_ERRADDR_OFF 12'h008
`define CTS_PCSNAP_OFF 12'h00c
`define CTS_MODALS_OFF 12'h010
`define CTS_EOI_OFF 12'h014
`define CTS_TRAPINFO_OFF 12'h018
`define CTS_CTRL_PXM 0
`define CTS_CTRL_HOLD 1
`define CTS_CTRL_TMR 2
`define CTS_CTRL_RST 3'h0
`define CTS_ST_IMM 0
`define CTS_ST_MCHK 1
`define CTS_ST_PAR 2
`define CTS_ST_MM 3
`define CTS_ST_UNC 4
`define CTS_ST_COR 5
`define CTS_ST_DMX 6
`define CTS_ST_IO 7
`define CTS_STATUS_RST 8'h00
`define CTS_CRM_CLEAR 2'h0
`define CTS_CRM_TWO 2'h2
`define CTS_EOI_VEC_LSB 16
`define CTS_HDR_POWER 16'h0080
`define CTS_HDR_PARITY 16'h00b8
`define CTS_HDR_MCHK 16'h00c0
`define CTS_HDR_MM 16'h00c8
`define CTS_HANDLER_OFS 16'h0004
`define CTS_CHECK_SEGMENT 16'h0004
`define CTS_REGADDR_V 32'h0000_0011
`define CTS_REGADDR_SR 32'h0000_001f
`define CTS_RING_PRIV 2'h0
`endif

// File: rtl/cts_pkg.sv
// Types shared by the check and trap sequencer.
`default_nettype none
package cts_pkg;
   typedef enum logic [2:0] {CHK_IDLE, CHK_HEADER, CHK_INHIBIT, CHK_MODE64, CHK_CRM,
      CHK_BRANCH, CHK_JST} cts_chk_state_t;
   typedef enum logic [3:0] {TK_NONE, TK_MISSING_MEM, TK_MCHK_UNC, TK_COR_ECC, TK_EXT_INT,
      TK_MEM_INC, TK_TIMER, TK_RESTRICT, TK_READ_ADDR, TK_TLB_MISS, TK_ACCESS,
      TK_PAGE_MOD} cts_trap_kind_t;
   typedef enum logic [1:0] {TR_IDLE, TR_SERVICE, TR_RETRY} cts_trap_state_t;
   typedef struct packed {
      logic valid;
      logic fetch;
      logic [15:0] upc;
      logic [31:0] pc;
      logic [31:0] eff_addr;
      logic v_mode;
      logic mem_read;
      logic mem_write;
      logic tlb_hit;
      logic access_ok;
      logic page_mod_bit;
      logic restricted_op;
      logic [1:0] ring;
      logic io_active;
      logic dmx_pending;
   } cts_step_t;
   typedef struct packed {
      logic mem_no_answer;
      logic machine_check;
      logic ecc_unc;
      logic ecc_cor;
      logic power_fail;
      logic env_fail;
      logic other_check;
      logic ext_int;
      logic mem_inc;
      logic timer_ovf;
      logic [31:0] mem_addr;
      logic [15:0] eoi_vector;
   } cts_event_t;
   typedef struct packed {
      logic take;
      cts_trap_kind_t kind;
      logic [15:0] trap_uaddr;
      logic abort_step;
      logic cache_fill;
      logic [4:0] fill_reg;
      logic tlb_load;
      logic set_modified;
      logic access_fault;
      logic restrict_fault;
      logic ext_intr;
      logic mem_inc_intr;
      logic timer_intr;
      logic [15:0] bus_vector;
      logic retry;
      logic [15:0] retry_uaddr;
   } cts_trap_act_t;
   typedef struct packed {
      cts_chk_state_t step;
      logic [15:0] segment;
      logic [15:0] header;
      logic [15:0] handler;
      logic [1:0] crm;
      logic sw_check;
      logic eoi_return;
   } cts_check_out_t;
endpackage : cts_pkg
`default_nettype wire

// File: rtl/cts_sequencer.sv
// Check entry, check deferral, trap priority and microstep retry sequencer.
//
// Functional notes
// - Exchange off: clear report mode, jump-and-store vector.
// - Exchange on: header, inhibit, 64V, mode, branch.
// - One record per check type; address/PC last.
// - Severe checks own address and PC snapshot.
// - Headers in segment four; handler four later.
// - Hold variant: wait for I/O idle, take.
// - Other variant: I/O check returns via end flag.
// - Other variant, correctable ECC outside I/O: end flag, mode two.
// - Power, environment, held correctable: at next fetch.
// - Unlisted checks give software check immediately.
// - I/O-time handling leaves I/O bus clean.
// - Trap saves location, services, retries the step.
// - Hardware traps outrank memory traps; missing first.
// - Register address read fills cache cell, use-once.
// - Translation miss aborts, loads buffer, retries.
// - Insufficient access rights raise access violation fault.
// - Write to unmodified page traps, sets modified.
// - Unanswered memory request raises missing memory trap.
// - Enabled timer trap interrupts, drives timer vector.
// - Restricted instruction outside ring zero faults.
// - External and memory increment traps raise interrupts.
// - Report mode is two bits of the modals.
`include "cts_defines.svh"
`default_nettype none
module cts_sequencer #(
   parameter logic [15:0] TRAP_UADDR = 16'h0100,
   parameter logic [15:0] TIMER_VECTOR = 16'h0040
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Microcode sequencer and memory side.
   input wire cts_pkg::cts_step_t step,
   input wire cts_pkg::cts_event_t evt,
   output logic step_stall,
   output cts_pkg::cts_trap_act_t trap_out,
   output cts_pkg::cts_check_out_t check_out
);
   logic [2:0] ctrl_reg, ctrl_next;
   logic [7:0] status_reg, status_next;
   logic [31:0] err_addr_reg, err_addr_next;
   logic [31:0] pc_snap_reg, pc_snap_next;
   logic [1:0] crm_reg, crm_next;
   logic eoi_reg, eoi_next;
   logic [15:0] eoi_vec_reg, eoi_vec_next;
   logic [3:0] pend_now_reg, pend_now_next;
   logic [3:0] pend_idle_reg, pend_idle_next;
   logic [3:0] pend_fetch_reg, pend_fetch_next;
   logic unc_reg, unc_next;
   cts_pkg::cts_chk_state_t chk_reg, chk_next;
   logic [1:0] cls_reg, cls_next;
   logic sw_check_reg, sw_check_next;
   logic eoi_ret_reg, eoi_ret_next;
   cts_pkg::cts_trap_state_t tr_reg, tr_next;
   cts_pkg::cts_trap_act_t act_reg, act_next;
   logic wr, rd, hold_var, io_time, severe, bus_idle;
   logic [3:0] eligible;
   cts_pkg::cts_trap_kind_t pick;

   // Header location of a check class: 0 power, 1 parity, 2 machine check, 3 missing.
   function automatic logic [15:0] header_of(input logic [1:0] cls);
      case (cls)
         2'd0: header_of = `CTS_HDR_POWER;
         2'd1: header_of = `CTS_HDR_PARITY;
         2'd2: header_of = `CTS_HDR_MCHK;
         default: header_of = `CTS_HDR_MM;
      endcase
   endfunction : header_of

   // Register-file window of the effective address for the current addressing mode.
   function automatic logic in_regfile(input cts_pkg::cts_step_t s);
      in_regfile = s.v_mode ? (s.eff_addr <= `CTS_REGADDR_V) : (s.eff_addr <= `CTS_REGADDR_SR);
   endfunction : in_regfile

   // Highest pending trap of the step; hardware group first.
   function automatic cts_pkg::cts_trap_kind_t trap_pick(input cts_pkg::cts_step_t s,
      input cts_pkg::cts_event_t e, input logic tmr_en);
      logic ref_any;
      ref_any = s.mem_read | s.mem_write;
      if (e.mem_no_answer)
         trap_pick = cts_pkg::TK_MISSING_MEM;
      else if (e.machine_check | e.ecc_unc)
         trap_pick = cts_pkg::TK_MCHK_UNC;
      else if (e.ecc_cor)
         trap_pick = cts_pkg::TK_COR_ECC;
      else if (s.fetch & e.ext_int)
         trap_pick = cts_pkg::TK_EXT_INT;
      else if (e.mem_inc)
         trap_pick = cts_pkg::TK_MEM_INC;
      else if (s.fetch & e.timer_ovf & tmr_en)
         trap_pick = cts_pkg::TK_TIMER;
      else if (s.restricted_op & (s.ring != `CTS_RING_PRIV))
         trap_pick = cts_pkg::TK_RESTRICT;
      else if (s.mem_read & in_regfile(s))
         trap_pick = cts_pkg::TK_READ_ADDR;
      else if (ref_any & ~s.tlb_hit)
         trap_pick = cts_pkg::TK_TLB_MISS;
      else if (ref_any & ~s.access_ok)
         trap_pick = cts_pkg::TK_ACCESS;
      else if (s.mem_write & ~s.page_mod_bit)
         trap_pick = cts_pkg::TK_PAGE_MOD;
      else
         trap_pick = cts_pkg::TK_NONE;
   endfunction : trap_pick

   assign wr = psel & penable & pwrite;
   assign rd = psel & ~pwrite;
   assign pready = 1'b1;
   assign hold_var = ctrl_reg[`CTS_CTRL_HOLD];
   assign io_time = step.io_active | step.dmx_pending;
   assign bus_idle = ~step.io_active & ~step.dmx_pending;
   assign severe = evt.mem_no_answer | evt.machine_check | evt.ecc_unc;
   assign pick = trap_pick(step, evt, ctrl_reg[`CTS_CTRL_TMR]);

   // APB read mux and error answer for unmapped words.
   always_comb
   begin
      prdata = 32'h0000_0000;
      pslverr = 1'b0;
      case (paddr)
         `CTS_CTRL_OFF: prdata = {29'h0000_0000, ctrl_reg};
         `CTS_STATUS_OFF: prdata = {24'h00_0000, status_reg};
         `CTS_ERRADDR_OFF: prdata = err_addr_reg;
         `CTS_PCSNAP_OFF: prdata = pc_snap_reg;
         `CTS_MODALS_OFF: prdata = {30'h0000_0000, crm_reg};
         `CTS_EOI_OFF: prdata = {eoi_vec_reg, 15'h0000, eoi_reg};
         `CTS_TRAPINFO_OFF: prdata = {act_reg.retry_uaddr, 12'h000, act_reg.kind};
         default: pslverr = psel & penable;
      endcase
      if (!rd)
         prdata = 32'h0000_0000;
   end

   // Status recording, snapshot ownership, deferral and end-of-instruction returns.
   always_comb
   begin
      logic [7:0] st_set;
      logic [7:0] st_clr;
      st_set = 8'h00;
      st_clr = 8'h00;
      ctrl_next = ctrl_reg;
      err_addr_next = err_addr_reg;
      pc_snap_next = pc_snap_reg;
      crm_next = crm_reg;
      eoi_next = eoi_reg;
      eoi_vec_next = eoi_vec_reg;
      pend_now_next = pend_now_reg;
      pend_idle_next = pend_idle_reg;
      pend_fetch_next = pend_fetch_reg;
      unc_next = unc_reg;
      sw_check_next = evt.other_check;
      eoi_ret_next = 1'b0;
      if (wr && paddr == `CTS_CTRL_OFF)
         ctrl_next = pwdata[2:0];
      if (wr && paddr == `CTS_STATUS_OFF)
         st_clr = pwdata[7:0];
      if (wr && paddr == `CTS_ERRADDR_OFF)
         err_addr_next = 32'h0000_0000;
      if (wr && paddr == `CTS_PCSNAP_OFF)
         pc_snap_next = 32'h0000_0000;
      if (wr && paddr == `CTS_MODALS_OFF)
         crm_next = pwdata[1:0];
      if (wr && paddr == `CTS_EOI_OFF && pwdata[0])
         eoi_next = 1'b0;
      if (evt.power_fail | evt.env_fail)
         pend_fetch_next[0] = 1'b1;
      if (severe | (evt.ecc_cor & ~(io_time & ~hold_var)))
      begin
         st_set[`CTS_ST_MM] = evt.mem_no_answer;
         st_set[`CTS_ST_MCHK] = evt.machine_check;
         st_set[`CTS_ST_PAR] = evt.ecc_unc | evt.ecc_cor;
         st_set[`CTS_ST_UNC] = evt.ecc_unc;
         st_set[`CTS_ST_COR] = evt.ecc_cor;
         st_set[`CTS_ST_IO] = step.io_active;
         st_set[`CTS_ST_DMX] = step.dmx_pending;
         if (severe || !(status_reg[`CTS_ST_MM] | status_reg[`CTS_ST_MCHK]
            | status_reg[`CTS_ST_UNC]))
         begin
            err_addr_next = evt.mem_addr;
            pc_snap_next = step.pc;
         end
      end
      if (severe)
      begin
         unc_next = evt.ecc_unc & ~evt.mem_no_answer & ~evt.machine_check;
         if (io_time && hold_var)
            pend_idle_next = {evt.mem_no_answer, evt.machine_check, evt.ecc_unc, 1'b0};
         else if (io_time)
         begin
            eoi_next = 1'b1;
            eoi_vec_next = evt.eoi_vector;
            crm_next = `CTS_CRM_CLEAR;
            eoi_ret_next = 1'b1;
         end
         else
         begin
            pend_now_next = pend_now_reg | {evt.mem_no_answer, evt.machine_check,
               evt.ecc_unc, 1'b0};
            st_set[`CTS_ST_IMM] = 1'b1;
         end
      end
      else if (evt.ecc_cor && hold_var)
         pend_fetch_next[1] = 1'b1;
      else if (evt.ecc_cor && !io_time)
      begin
         eoi_next = 1'b1;
         eoi_vec_next = evt.eoi_vector;
         crm_next = `CTS_CRM_TWO;
         eoi_ret_next = 1'b1;
      end
      if (chk_reg == cts_pkg::CHK_IDLE && eligible != 4'h0)
      begin
         pend_now_next[cls_next] = 1'b0;
         pend_idle_next[cls_next] = 1'b0;
         pend_fetch_next[cls_next] = 1'b0;
      end
      if (chk_reg == cts_pkg::CHK_CRM)
      begin
         if (ctrl_reg[`CTS_CTRL_PXM] && cls_reg == 2'd1 && unc_reg)
            crm_next = `CTS_CRM_TWO;
         else
            crm_next = `CTS_CRM_CLEAR;
      end
      status_next = (status_reg & ~st_clr) | st_set;
   end

   // Check entry sequence; held checks wait for an idle bus, deferred ones for a fetch.
   always_comb
   begin
      eligible = pend_now_reg | (bus_idle ? pend_idle_reg : 4'h0)
         | (step.fetch ? pend_fetch_reg : 4'h0);
      chk_next = chk_reg;
      cls_next = cls_reg;
      case (chk_reg)
         cts_pkg::CHK_IDLE:
         begin
            if (eligible[3])
               cls_next = 2'd3;
            else if (eligible[2])
               cls_next = 2'd2;
            else if (eligible[1])
               cls_next = 2'd1;
            else
               cls_next = 2'd0;
            if (eligible != 4'h0)
               chk_next = ctrl_reg[`CTS_CTRL_PXM] ? cts_pkg::CHK_HEADER : cts_pkg::CHK_CRM;
         end
         cts_pkg::CHK_HEADER: chk_next = cts_pkg::CHK_INHIBIT;
         cts_pkg::CHK_INHIBIT: chk_next = cts_pkg::CHK_MODE64;
         cts_pkg::CHK_MODE64: chk_next = cts_pkg::CHK_CRM;
         cts_pkg::CHK_CRM:
            chk_next = ctrl_reg[`CTS_CTRL_PXM] ? cts_pkg::CHK_BRANCH : cts_pkg::CHK_JST;
         default: chk_next = cts_pkg::CHK_IDLE;
      endcase
   end

   // Trap service: save location, act, then retry the trapped step.
   always_comb
   begin
      act_next = act_reg;
      act_next.take = 1'b0;
      act_next.abort_step = 1'b0;
      act_next.cache_fill = 1'b0;
      act_next.tlb_load = 1'b0;
      act_next.set_modified = 1'b0;
      act_next.access_fault = 1'b0;
      act_next.restrict_fault = 1'b0;
      act_next.ext_intr = 1'b0;
      act_next.mem_inc_intr = 1'b0;
      act_next.timer_intr = 1'b0;
      act_next.retry = 1'b0;
      tr_next = tr_reg;
      case (tr_reg)
         cts_pkg::TR_IDLE:
            if (step.valid && pick != cts_pkg::TK_NONE)
            begin
               tr_next = cts_pkg::TR_SERVICE;
               act_next.take = 1'b1;
               act_next.kind = pick;
               act_next.trap_uaddr = TRAP_UADDR;
               act_next.retry_uaddr = step.upc;
               act_next.abort_step = 1'b1;
               act_next.cache_fill = (pick == cts_pkg::TK_READ_ADDR);
               act_next.fill_reg = step.eff_addr[4:0];
               act_next.tlb_load = (pick == cts_pkg::TK_TLB_MISS);
               act_next.access_fault = (pick == cts_pkg::TK_ACCESS);
               act_next.set_modified = (pick == cts_pkg::TK_PAGE_MOD);
               act_next.restrict_fault = (pick == cts_pkg::TK_RESTRICT);
               act_next.ext_intr = (pick == cts_pkg::TK_EXT_INT);
               act_next.mem_inc_intr = (pick == cts_pkg::TK_MEM_INC);
               act_next.timer_intr = (pick == cts_pkg::TK_TIMER);
               act_next.bus_vector = (pick == cts_pkg::TK_TIMER) ? TIMER_VECTOR : 16'h0000;
            end
         cts_pkg::TR_SERVICE:
         begin
            tr_next = cts_pkg::TR_RETRY;
            act_next.retry = 1'b1;
         end
         default: tr_next = cts_pkg::TR_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= `CTS_CTRL_RST;
         status_reg <= `CTS_STATUS_RST;
         err_addr_reg <= 32'h0000_0000;
         pc_snap_reg <= 32'h0000_0000;
         crm_reg <= `CTS_CRM_CLEAR;
         eoi_reg <= 1'b0;
         eoi_vec_reg <= 16'h0000;
         pend_now_reg <= 4'h0;
         pend_idle_reg <= 4'h0;
         pend_fetch_reg <= 4'h0;
         unc_reg <= 1'b0;
         chk_reg <= cts_pkg::CHK_IDLE;
         cls_reg <= 2'd0;
         sw_check_reg <= 1'b0;
         eoi_ret_reg <= 1'b0;
         tr_reg <= cts_pkg::TR_IDLE;
         act_reg <= '0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         status_reg <= status_next;
         err_addr_reg <= err_addr_next;
         pc_snap_reg <= pc_snap_next;
         crm_reg <= crm_next;
         eoi_reg <= eoi_next;
         eoi_vec_reg <= eoi_vec_next;
         pend_now_reg <= pend_now_next;
         pend_idle_reg <= pend_idle_next;
         pend_fetch_reg <= pend_fetch_next;
         unc_reg <= unc_next;
         chk_reg <= chk_next;
         cls_reg <= cls_next;
         sw_check_reg <= sw_check_next;
         eoi_ret_reg <= eoi_ret_next;
         tr_reg <= tr_next;
         act_reg <= act_next;
      end
   end

   assign step_stall = (tr_reg != cts_pkg::TR_IDLE);
   assign trap_out = act_reg;
   assign check_out.step = chk_reg;
   assign check_out.segment = `CTS_CHECK_SEGMENT;
   assign check_out.header = header_of(cls_reg);
   assign check_out.handler = header_of(cls_reg) + `CTS_HANDLER_OFS;
   assign check_out.crm = crm_reg;
   assign check_out.sw_check = sw_check_reg;
   assign check_out.eoi_return = eoi_ret_reg;

   chk_jst_crm_zero: assert property (@(posedge pclk) disable iff (!presetn)
      chk_reg == cts_pkg::CHK_JST |-> crm_reg == `CTS_CRM_CLEAR && !ctrl_reg[`CTS_CTRL_PXM])
      else $error("jump-and-store with report mode not cleared");
   chk_pxm_entry_order: assert property (@(posedge pclk) disable iff (!presetn)
      chk_reg == cts_pkg::CHK_HEADER |=> chk_reg == cts_pkg::CHK_INHIBIT
      ##1 chk_reg == cts_pkg::CHK_MODE64 ##1 chk_reg == cts_pkg::CHK_CRM
      ##1 chk_reg == cts_pkg::CHK_BRANCH ##1 chk_reg == cts_pkg::CHK_IDLE)
      else $error("exchange check entry out of order");
   chk_severe_snapshot: assert property (@(posedge pclk) disable iff (!presetn)
      severe |=> err_addr_reg == $past(evt.mem_addr) && pc_snap_reg == $past(step.pc))
      else $error("severe check did not own address snapshot");
   chk_handler_offset: assert property (@(posedge pclk) disable iff (!presetn)
      chk_reg == cts_pkg::CHK_BRANCH |-> check_out.handler - check_out.header == 16'h0004)
      else $error("handler not four words after header");
   chk_power_no_record: assert property (@(posedge pclk) disable iff (!presetn)
      (evt.power_fail && !severe && !evt.ecc_cor && !wr) |=> $stable(status_reg))
      else $error("power check changed status words");
   chk_io_eoi_return: assert property (@(posedge pclk) disable iff (!presetn)
      (severe && io_time && !hold_var) |=> eoi_reg && eoi_ret_reg && crm_reg == 2'h0)
      else $error("I/O-time check did not return via end flag");
   chk_cor_mode_two: assert property (@(posedge pclk) disable iff (!presetn)
      (evt.ecc_cor && !severe && !io_time && !hold_var && chk_reg != cts_pkg::CHK_CRM)
      |=> eoi_reg && crm_reg == 2'h2)
      else $error("correctable check did not set mode two");
   chk_trap_retry: assert property (@(posedge pclk) disable iff (!presetn)
      (tr_reg == cts_pkg::TR_IDLE && step.valid && pick != cts_pkg::TK_NONE)
      |=> trap_out.take ##1 trap_out.retry && trap_out.retry_uaddr == $past(step.upc, 2))
      else $error("trapped step not retried at saved location");
   chk_missing_first: assert property (@(posedge pclk) disable iff (!presetn)
      (tr_reg == cts_pkg::TR_IDLE && step.valid && evt.mem_no_answer)
      |=> trap_out.kind == cts_pkg::TK_MISSING_MEM)
      else $error("missing memory trap lost priority");
endmodule : cts_sequencer
`default_nettype wire

// File: test/cts_ucode_model.sv
// Behavioural microcode sequencer that re-presents the trapped step after service.
`default_nettype none
module cts_ucode_model (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Step asked for by the bench, and the block's trap actions.
   input wire cts_pkg::cts_step_t req,
   input wire cts_pkg::cts_trap_act_t trap_out,
   // Step seen by the block.
   output cts_pkg::cts_step_t step
);
   logic [3:0] fix_reg;
   logic [3:0] fix_next;
   always_comb
   begin
      fix_next = req.valid ? fix_reg : 4'h0;
      if (trap_out.take)
         fix_next = fix_next | {trap_out.tlb_load, trap_out.set_modified, trap_out.cache_fill,
            trap_out.access_fault | trap_out.restrict_fault};
   end
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         fix_reg <= 4'h0;
      else
         fix_reg <= fix_next;
   // A serviced fault sends the microcode elsewhere, so the step is withdrawn.
   always_comb
   begin
      step = req;
      step.tlb_hit = req.tlb_hit | fix_reg[3];
      step.page_mod_bit = req.page_mod_bit | fix_reg[2];
      step.mem_read = req.mem_read & ~fix_reg[1];
      step.valid = req.valid & ~fix_reg[0];
   end
endmodule : cts_ucode_model
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the check and trap sequencer.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, step_stall, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   cts_pkg::cts_step_t req, step, b, s;
   cts_pkg::cts_event_t evt, e0, e;
   cts_pkg::cts_trap_act_t trap_out;
   cts_pkg::cts_check_out_t check_out;
   int n_errors = 0;
   int checks = 0;
   int cycles = 0;
   cts_sequencer cts_sequencer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .step(step), .evt(evt), .step_stall(step_stall),
      .trap_out(trap_out), .check_out(check_out));
   cts_ucode_model cts_ucode_model_inst (.pclk(pclk), .presetn(presetn), .req(req),
      .trap_out(trap_out), .step(step));
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         n_errors++;
         final_report();
      end
   end
   task automatic final_report();
      if (n_errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   // Presents one step with an event, then follows take, retry and the re-presented step.
   task automatic trap(input cts_pkg::cts_step_t st, input cts_pkg::cts_event_t ev,
      input cts_pkg::cts_trap_kind_t k, input cts_pkg::cts_trap_kind_t k2, input logic [4:0] act);
      @(posedge pclk);
      req <= st;
      evt <= ev;
      @(posedge pclk);
      evt <= e0;
      #1;
      check("take kind", {trap_out.take, trap_out.kind}, {1'b1, k});
      check("stall", step_stall, 32'h1);
      check("actions", {trap_out.cache_fill, trap_out.tlb_load, trap_out.set_modified,
         trap_out.access_fault, trap_out.restrict_fault}, act);
      @(posedge pclk);
      #1;
      check("retry", {trap_out.retry, trap_out.retry_uaddr}, {1'b1, st.upc});
      // The trap machine is idle again one edge after retry; the step is re-judged at the next.
      @(posedge pclk);
      @(posedge pclk);
      req.valid <= 1'b0;
      #1;
      check("next trap", {trap_out.take, trap_out.kind}, {k2 != cts_pkg::TK_NONE,
         k2 == cts_pkg::TK_NONE ? k : k2});
      repeat (4) @(posedge pclk);
   endtask : trap
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, req, evt, e0} = '0;
      presetn = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h010, 32'h0);
      check("modals reset", rd, 32'h0);
      apb(1'b0, 12'h01c, 32'h0);
      check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
      apb(1'b1, 12'h000, 32'h0000_0001);
      @(posedge pclk);
      {evt.ecc_unc, evt.mem_addr} <= {1'b1, 32'h0000_1234};
      @(posedge pclk);
      evt <= e0;
      #1;
      for (int i = 0; i < 8 && check_out.step !== cts_pkg::CHK_HEADER; i++)
         @(posedge pclk) #1;
      check("vectors", {check_out.header, check_out.handler}, 32'h00b8_00bc);
      check("segment", check_out.segment, 32'h4);
      for (int i = 1; i <= 5; i++)
      begin
         check("chk step", 32'(check_out.step), i);
         if (i == 5)
            check("crm", 32'(check_out.crm), 32'h2);
         @(posedge pclk) #1;
      end
      apb(1'b1, 12'h000, 32'h0);
      @(posedge pclk);
      {evt.ecc_cor, evt.mem_addr} <= {1'b1, 32'h0000_5678};
      @(posedge pclk);
      evt <= e0;
      repeat (6) @(posedge pclk);
      apb(1'b0, 12'h014, 32'h0);
      check("eoi flag", rd[0], 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      check("crm two", rd[1:0], 32'h2);
      apb(1'b0, 12'h008, 32'h0);
      check("err addr", rd, 32'h0000_1234);
      apb(1'b0, 12'h004, 32'h0);
      check("status", rd & 32'h30, 32'h30);
      apb(1'b1, 12'h004, 32'h0000_00ff);
      apb(1'b0, 12'h004, 32'h0);
      check("status clear", rd, 32'h0);
      evt.power_fail <= 1'b1;
      @(posedge pclk);
      evt <= e0;
      repeat (3) @(posedge pclk);
      #1;
      check("power waits", 32'(check_out.step), 32'h0);
      @(posedge pclk);
      req.fetch <= 1'b1;
      @(posedge pclk) #1;
      check("power entry", {check_out.header, 16'(check_out.step)}, 32'h0080_0004);
      @(posedge pclk);
      req.fetch <= 1'b0;
      apb(1'b0, 12'h004, 32'h0);
      check("power status", rd, 32'h0);
      b = '0;
      {b.valid, b.upc, b.eff_addr, b.mem_read} = {1'b1, 16'h0123, 32'h0000_1000, 1'b1};
      {b.tlb_hit, b.access_ok, b.page_mod_bit} = 3'b111;
      s = b;
      s.tlb_hit = 1'b0;
      trap(s, e0, cts_pkg::TK_TLB_MISS, cts_pkg::TK_NONE, 5'b01000);
      e = e0;
      e.mem_no_answer = 1'b1;
      trap(s, e, cts_pkg::TK_MISSING_MEM, cts_pkg::TK_TLB_MISS, 5'b00000);
      s = b;
      {s.v_mode, s.eff_addr} = {1'b1, 32'h0000_0011};
      trap(s, e0, cts_pkg::TK_READ_ADDR, cts_pkg::TK_NONE, 5'b10000);
      {s.v_mode, s.eff_addr, s.tlb_hit} = {1'b0, 32'h0000_0020, 1'b0};
      trap(s, e0, cts_pkg::TK_TLB_MISS, cts_pkg::TK_NONE, 5'b01000);
      s = b;
      s.access_ok = 1'b0;
      trap(s, e0, cts_pkg::TK_ACCESS, cts_pkg::TK_NONE, 5'b00010);
      s = b;
      {s.mem_write, s.page_mod_bit} = 2'b10;
      trap(s, e0, cts_pkg::TK_PAGE_MOD, cts_pkg::TK_NONE, 5'b00100);
      {s.restricted_op, s.ring} = {1'b1, 2'h1};
      trap(s, e0, cts_pkg::TK_RESTRICT, cts_pkg::TK_NONE, 5'b00001);
      final_report();
   end
endmodule : testbench
`default_nettype wire
